// >>> hdl/ccr_defines.svh
// Purpose: Constants for the core configuration and control register bank
// Assumes: Included by bare name
// Notes: Positions and reset values of the extended control fields
`ifndef CCR_DEFINES_SVH
`define CCR_DEFINES_SVH
// --------------------------------------------------------------
// Register selectors
// --------------------------------------------------------------
`define CCR_SEL_AUX 2'h0
`define CCR_SEL_CFG 2'h1
`define CCR_SEL_ECTL 2'h2
// --------------------------------------------------------------
// Field positions and reset values
// --------------------------------------------------------------
`define CCR_CFG_ECC_PRESENT 2'h1
`define CCR_ECTL_WMASK 64'h0000_00e0_3f40_fc00
`define CCR_ECTL_RESET 64'h0000_0000_1400_bc00
`define CCR_ATOM_LSB 38
`define CCR_FLUSH_BIT 37
`define CCR_L3WS_LSB 28
`define CCR_L2WS_LSB 26
`define CCR_L1WS_LSB 24
`define CCR_STBPF_BIT 22
`define CCR_L1PD_LSB 13
`define CCR_L3PD_LSB 10
// --------------------------------------------------------------
// Streaming thresholds in lines and L3 prefetch disable code
// --------------------------------------------------------------
`define CCR_L3WS_T0 13'h0080
`define CCR_L3WS_T1 13'h0400
`define CCR_L3WS_T2 13'h1000
`define CCR_L2WS_T0 13'h0010
`define CCR_L2WS_T1 13'h0080
`define CCR_L2WS_T2 13'h0200
`define CCR_L1WS_T0 13'h0004
`define CCR_L1WS_T1 13'h0040
`define CCR_L1WS_T2 13'h0080
`define CCR_L3PD_OFF 3'h4
`endif

// >>> hdl/ccr_pkg.sv
// Purpose: Types of the core configuration and control register bank
// Assumes: Nothing
// Notes: Decoded controls travel as one struct
package ccr_pkg;
  typedef enum logic [1:0] {
    CCR_EL0 = 2'b00,
    CCR_EL1 = 2'b01,
    CCR_EL2 = 2'b10,
    CCR_EL3 = 2'b11
  } ccr_el_e;
  typedef enum logic [1:0] {
    CCR_TRAP_NONE = 2'b00,
    CCR_TRAP_EL2 = 2'b01,
    CCR_TRAP_EL3 = 2'b10
  } ccr_trap_e;
  typedef struct packed {
    logic ld_atomic_near;
    logic st_atomic_near;
    logic powerdown_clean_discard;
    logic [12:0] l3_stream_lines;
    logic [12:0] l2_stream_lines;
    logic [12:0] l1_stream_lines;
    logic l3_stream_off;
    logic l2_stream_off;
    logic l1_stream_off;
    logic store_buffer_prefetch_train;
    logic [2:0] l1_prefetch_depth;
    logic [5:0] l3_prefetch_lines;
    logic l3_prefetch_on;
  } ccr_ctrl_s;
endpackage

// >>> hdl/ccr_access_gate.sv
// Purpose: Write permission check for the auxiliary control register
// Assumes: Current level and enables come from the same clock domain
// Notes: Purely combinational
`timescale 1ns/1ps
`include "ccr_defines.svh"
module ccr_access_gate (
  input wire ccr_pkg::ccr_el_e el_in,
  input wire logic el3_en_in,
  input wire logic el2_en_in,
  input wire logic ns_in,
  output logic allow_out,
  output ccr_pkg::ccr_trap_e trap_out
);
  always_comb
  begin
    allow_out = 1'b0;
    trap_out = ccr_pkg::CCR_TRAP_NONE;
    unique case (el_in)
      ccr_pkg::CCR_EL3:
      begin
        allow_out = 1'b1;
      end
      ccr_pkg::CCR_EL2:
      begin
        allow_out = el3_en_in;
        if (!el3_en_in)
          trap_out = ccr_pkg::CCR_TRAP_EL3;
      end
      ccr_pkg::CCR_EL1:
      begin
        allow_out = el3_en_in && (el2_en_in || !ns_in);
        // Lowest denying level: EL2 wins whenever it refuses, even if EL3 refuses too
        if (!el2_en_in && ns_in)
          trap_out = ccr_pkg::CCR_TRAP_EL2;
        else if (!el3_en_in)
          trap_out = ccr_pkg::CCR_TRAP_EL3;
      end
      ccr_pkg::CCR_EL0:
      begin
        allow_out = 1'b0;
        trap_out = ccr_pkg::CCR_TRAP_NONE;
      end
    endcase
  end
endmodule

// >>> hdl/ccr_field_decode.sv
// Purpose: Turns extended control fields into cache and prefetch controls
// Assumes: Input is the stored register value
// Notes: Outputs registered so consumers see flop data
`timescale 1ns/1ps
`include "ccr_defines.svh"
module ccr_field_decode (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic [63:0] ectl_in,
  input wire logic st_hit_unique_in,
  output ccr_pkg::ccr_ctrl_s ctrl_out
);
  function automatic logic [12:0] ws_lines(input logic [1:0] code, input logic [12:0] t0,
                                            input logic [12:0] t1, input logic [12:0] t2);
    unique case (code)
      2'h0: ws_lines = t0;
      2'h1: ws_lines = t1;
      2'h2: ws_lines = t2;
      2'h3: ws_lines = 13'h0000;
    endcase
  endfunction
  ccr_pkg::ccr_ctrl_s ctrl_nxt;
  logic [1:0] atom;
  logic [2:0] l3pd;
  always_comb
  begin
    atom = ectl_in[`CCR_ATOM_LSB +: 2];
    l3pd = ectl_in[`CCR_L3PD_LSB +: 3];
    ctrl_nxt = '0;
    unique case (atom)
      2'h0:
      begin
        ctrl_nxt.ld_atomic_near = 1'b1;
        ctrl_nxt.st_atomic_near = st_hit_unique_in;
      end
      2'h1:
      begin
        ctrl_nxt.ld_atomic_near = 1'b1;
        ctrl_nxt.st_atomic_near = 1'b1;
      end
      2'h2:
      begin
        ctrl_nxt.ld_atomic_near = 1'b0;
        ctrl_nxt.st_atomic_near = 1'b0;
      end
      2'h3:
      begin
        ctrl_nxt.ld_atomic_near = 1'b1;
        ctrl_nxt.st_atomic_near = st_hit_unique_in;
      end
    endcase
    ctrl_nxt.powerdown_clean_discard = ectl_in[`CCR_FLUSH_BIT];
    ctrl_nxt.l3_stream_lines = ws_lines(ectl_in[`CCR_L3WS_LSB +: 2], `CCR_L3WS_T0,
                                        `CCR_L3WS_T1, `CCR_L3WS_T2);
    ctrl_nxt.l3_stream_off = &ectl_in[`CCR_L3WS_LSB +: 2];
    ctrl_nxt.l2_stream_lines = ws_lines(ectl_in[`CCR_L2WS_LSB +: 2], `CCR_L2WS_T0,
                                        `CCR_L2WS_T1, `CCR_L2WS_T2);
    ctrl_nxt.l2_stream_off = &ectl_in[`CCR_L2WS_LSB +: 2];
    ctrl_nxt.l1_stream_lines = ws_lines(ectl_in[`CCR_L1WS_LSB +: 2], `CCR_L1WS_T0,
                                        `CCR_L1WS_T1, `CCR_L1WS_T2);
    ctrl_nxt.l1_stream_off = &ectl_in[`CCR_L1WS_LSB +: 2];
    ctrl_nxt.store_buffer_prefetch_train = !ectl_in[`CCR_STBPF_BIT];
    ctrl_nxt.l1_prefetch_depth = ectl_in[`CCR_L1PD_LSB +: 3];
    ctrl_nxt.l3_prefetch_on = 1'b1;
    unique case (l3pd)
      3'h0: ctrl_nxt.l3_prefetch_lines = 6'h10;
      3'h1: ctrl_nxt.l3_prefetch_lines = 6'h20;
      3'h5: ctrl_nxt.l3_prefetch_lines = 6'h02;
      3'h6: ctrl_nxt.l3_prefetch_lines = 6'h04;
      3'h7: ctrl_nxt.l3_prefetch_lines = 6'h08;
      default:
      begin
        // Disable code and the two reserved codes all stop the prefetcher
        ctrl_nxt.l3_prefetch_lines = 6'h00;
        ctrl_nxt.l3_prefetch_on = 1'b0;
      end
    endcase
  end
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      ctrl_out <= '0;
    else
      ctrl_out <= ctrl_nxt;
  end
endmodule

// >>> hdl/ccr_regs.sv
// Purpose: Core configuration and control register bank
// Assumes: One system-register access per cycle, core clock domain
// Notes: Auxiliary register contents live elsewhere; this bank only gates it
`timescale 1ns/1ps
`include "ccr_defines.svh"
module ccr_regs (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [1:0] req_sel_in,
  input wire logic [63:0] req_wdata_in,
  input wire ccr_pkg::ccr_el_e req_el_in,
  input wire logic el3_aux_access_ctrl_in,
  input wire logic el2_aux_access_ctrl_in,
  input wire logic nonsecure_state_bit_in,
  input wire logic st_hit_unique_in,
  output logic [63:0] rdata_out,
  output logic aux_write_en_out,
  output ccr_pkg::ccr_trap_e trap_out,
  output logic [63:0] ectl_out,
  output ccr_pkg::ccr_ctrl_s ctrl_out
);
  // --------------------------------------------------------------
  // Access gate
  // --------------------------------------------------------------
  logic aux_allow;
  ccr_pkg::ccr_trap_e aux_trap;
  logic aux_wr;
  ccr_access_gate u_gate (
    .el_in(req_el_in),
    .el3_en_in(el3_aux_access_ctrl_in),
    .el2_en_in(el2_aux_access_ctrl_in),
    .ns_in(nonsecure_state_bit_in),
    .allow_out(aux_allow),
    .trap_out(aux_trap)
  );
  assign aux_wr = req_valid_in && req_write_in && (req_sel_in == `CCR_SEL_AUX);
  // Aux enable is a pulse to the auxiliary store; traps are pulses too
  assign aux_write_en_out = aux_wr && aux_allow;
  assign trap_out = aux_wr ? aux_trap : ccr_pkg::CCR_TRAP_NONE;
  // --------------------------------------------------------------
  // Extended control register
  // --------------------------------------------------------------
  logic [63:0] ectl_r;
  logic [63:0] ectl_nxt;
  always_comb
  begin
    ectl_nxt = ectl_r;
    // No idle check: writes land whenever issued
    if (req_valid_in && req_write_in && (req_sel_in == `CCR_SEL_ECTL))
      ectl_nxt = req_wdata_in & `CCR_ECTL_WMASK;
  end
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      ectl_r <= `CCR_ECTL_RESET;
    else
      ectl_r <= ectl_nxt;
  end
  assign ectl_out = ectl_r;
  // --------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rdata_out <= 64'h0;
    else if (req_valid_in && !req_write_in)
    begin
      if (req_sel_in == `CCR_SEL_CFG)
        rdata_out <= {62'h0, `CCR_CFG_ECC_PRESENT};
      else if (req_sel_in == `CCR_SEL_ECTL)
        rdata_out <= ectl_r;
      else
        rdata_out <= 64'h0;
    end
  end
  ccr_field_decode u_dec (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .ectl_in(ectl_r),
    .st_hit_unique_in(st_hit_unique_in),
    .ctrl_out(ctrl_out)
  );
  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  sequence s_ectl_wr;
    req_valid_in && req_write_in && (req_sel_in == `CCR_SEL_ECTL);
  endsequence
  property p_el2_gate;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (aux_wr && req_el_in == ccr_pkg::CCR_EL2) |->
      (aux_write_en_out == el3_aux_access_ctrl_in);
  endproperty
  a_el2_gate: assert property (p_el2_gate) else $error("EL2 aux gate wrong");
  property p_el1_gate;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (aux_wr && req_el_in == ccr_pkg::CCR_EL1) |-> (aux_write_en_out ==
      (el3_aux_access_ctrl_in && (el2_aux_access_ctrl_in || !nonsecure_state_bit_in)));
  endproperty
  a_el1_gate: assert property (p_el1_gate) else $error("EL1 aux gate wrong");
  property p_trap_el2;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (aux_wr && req_el_in == ccr_pkg::CCR_EL1 && !el2_aux_access_ctrl_in &&
     nonsecure_state_bit_in) |-> trap_out == ccr_pkg::CCR_TRAP_EL2;
  endproperty
  a_trap_el2: assert property (p_trap_el2) else $error("Trap not to EL2");
  property p_trap_el3;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (aux_wr && req_el_in == ccr_pkg::CCR_EL2 && !el3_aux_access_ctrl_in) |->
      trap_out == ccr_pkg::CCR_TRAP_EL3;
  endproperty
  a_trap_el3: assert property (p_trap_el3) else $error("Trap not to EL3");
  property p_cfg_read;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (req_valid_in && !req_write_in && req_sel_in == `CCR_SEL_CFG) |=> rdata_out == 64'h1;
  endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("Config read wrong");
  property p_ectl_res;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (ectl_r & ~`CCR_ECTL_WMASK) == 64'h0;
  endproperty
  a_ectl_res: assert property (p_ectl_res) else $error("Reserved bit set");
  property p_ectl_wr;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    s_ectl_wr |=> ectl_r == ($past(req_wdata_in) & `CCR_ECTL_WMASK);
  endproperty
  a_ectl_wr: assert property (p_ectl_wr) else $error("Ext control not written");
  property p_ectl_read;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (req_valid_in && !req_write_in && req_sel_in == `CCR_SEL_ECTL) |=>
      rdata_out[63:40] == 24'h0 && rdata_out == $past(ectl_r);
  endproperty
  a_ectl_read: assert property (p_ectl_read) else $error("Ext read wrong");
  property p_far_atomic;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (ectl_r[`CCR_ATOM_LSB +: 2] == 2'h2) |=> !ctrl_out.ld_atomic_near && !ctrl_out.st_atomic_near;
  endproperty
  a_far_atomic: assert property (p_far_atomic) else $error("Far atomic wrong");
  property p_l3_off;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (ectl_r[`CCR_L3PD_LSB +: 3] == `CCR_L3PD_OFF) |=> !ctrl_out.l3_prefetch_on;
  endproperty
  a_l3_off: assert property (p_l3_off) else $error("L3 prefetch not off");
  property p_stb;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    ectl_r[`CCR_STBPF_BIT] |=> !ctrl_out.store_buffer_prefetch_train;
  endproperty
  a_stb: assert property (p_stb) else $error("Store buffer training on");
endmodule

// >>> verification/tb_top.sv
// Purpose: Self-checking bench for the configuration and control register bank
// Assumes: Inputs driven on the falling edge, one access per cycle
// Notes: Expected values are worked out here, never read back from the design
`timescale 1ns/1ps
module tb_top;
  // ------------------------------------------------------------
  // Stimulus and observation
  // ------------------------------------------------------------
  typedef struct {
    logic [1:0] el;
    logic e3;
    logic e2;
    logic ns;
    logic allow;
    logic [1:0] trap;
  } ccr_gate_row_s;
  logic ref_clk_in, rst_n_in, req_valid_in, req_write_in, st_hit_unique_in;
  logic [1:0] req_sel_in;
  logic [63:0] req_wdata_in, rdata_out, ectl_out, d;
  ccr_pkg::ccr_el_e req_el_in;
  logic el3_aux_access_ctrl_in, el2_aux_access_ctrl_in, nonsecure_state_bit_in;
  logic aux_write_en_out;
  ccr_pkg::ccr_trap_e trap_out;
  ccr_pkg::ccr_ctrl_s ctrl_out;
  int fails = 0;
  int tests_run = 0;
  int a;
  // Writable fields and reset value worked out from the field list
  localparam logic [63:0] MASK = 64'h0000_00e0_3f40_fc00;
  localparam logic [63:0] RSTV = 64'h0000_0000_1400_bc00;
  int l3t[4] = '{128, 1024, 4096, 0};
  int l2t[4] = '{16, 128, 512, 0};
  int l1t[4] = '{4, 64, 128, 0};
  int l3pl[8] = '{16, 32, 0, 0, 0, 2, 4, 8};
  ccr_gate_row_s rows[10] = '{
    '{2'h3, 1'b0, 1'b0, 1'b1, 1'b1, 2'h0}, '{2'h2, 1'b1, 1'b0, 1'b1, 1'b1, 2'h0},
    '{2'h2, 1'b0, 1'b1, 1'b1, 1'b0, 2'h2}, '{2'h1, 1'b1, 1'b1, 1'b1, 1'b1, 2'h0},
    '{2'h1, 1'b1, 1'b0, 1'b0, 1'b1, 2'h0}, '{2'h1, 1'b1, 1'b0, 1'b1, 1'b0, 2'h1},
    '{2'h1, 1'b0, 1'b1, 1'b1, 1'b0, 2'h2}, '{2'h1, 1'b0, 1'b0, 1'b0, 1'b0, 2'h2},
    '{2'h0, 1'b1, 1'b1, 1'b1, 1'b0, 2'h0}, '{2'h1, 1'b0, 1'b0, 1'b1, 1'b0, 2'h1}};

  ccr_regs dut_u (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .req_valid_in(req_valid_in),
    .req_write_in(req_write_in), .req_sel_in(req_sel_in), .req_wdata_in(req_wdata_in),
    .req_el_in(req_el_in), .el3_aux_access_ctrl_in(el3_aux_access_ctrl_in),
    .el2_aux_access_ctrl_in(el2_aux_access_ctrl_in),
    .nonsecure_state_bit_in(nonsecure_state_bit_in), .st_hit_unique_in(st_hit_unique_in),
    .rdata_out(rdata_out), .aux_write_en_out(aux_write_en_out), .trap_out(trap_out),
    .ectl_out(ectl_out), .ctrl_out(ctrl_out));

  initial
  begin
    ref_clk_in = 1'b0;
    forever #50 ref_clk_in = ~ref_clk_in;
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_trap(input ccr_pkg::ccr_trap_e got, input logic [1:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic acc(input logic wr, input logic [1:0] sel, input logic [63:0] wd);
    @(negedge ref_clk_in);
    req_valid_in = 1'b1;
    req_write_in = wr;
    req_sel_in = sel;
    req_wdata_in = wd;
    @(negedge ref_clk_in);
    req_valid_in = 1'b0;
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Whole run is under 60 cycles; this limit of 3000 cycles leaves wide margin
  initial
  begin
    #(3000 * 100);
    fails++;
    wrap_up();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    rst_n_in = 1'b0;
    {req_valid_in, req_write_in, st_hit_unique_in} = 3'h0;
    req_sel_in = 2'h0;
    req_wdata_in = 64'h0;
    req_el_in = ccr_pkg::CCR_EL1;
    {el3_aux_access_ctrl_in, el2_aux_access_ctrl_in, nonsecure_state_bit_in} = 3'h0;
    repeat (5) @(negedge ref_clk_in);
    rst_n_in = 1'b1;
    @(negedge ref_clk_in);
    chk(ectl_out, RSTV);
    chk({ctrl_out.ld_atomic_near, ctrl_out.powerdown_clean_discard}, 64'h2);
    chk(ctrl_out.l3_stream_lines, 64'd1024);
    chk(ctrl_out.l2_stream_lines, 64'd128);
    chk(ctrl_out.l1_stream_lines, 64'd4);
    chk(ctrl_out.store_buffer_prefetch_train, 64'h1);
    chk(ctrl_out.l1_prefetch_depth, 64'h5);
    chk({ctrl_out.l3_prefetch_lines, ctrl_out.l3_prefetch_on}, 64'd17);
    $display("test reset values done");
    // Gate table, back to back aux writes
    foreach (rows[i])
    begin
      @(negedge ref_clk_in);
      {req_valid_in, req_write_in, req_sel_in} = 4'hc;
      req_el_in = ccr_pkg::ccr_el_e'(rows[i].el);
      el3_aux_access_ctrl_in = rows[i].e3;
      el2_aux_access_ctrl_in = rows[i].e2;
      nonsecure_state_bit_in = rows[i].ns;
      #1;
      chk(aux_write_en_out, rows[i].allow);
      chk_trap(trap_out, rows[i].trap);
    end
    // A read of the aux register under denying enables must not trap
    @(negedge ref_clk_in);
    {req_write_in, el3_aux_access_ctrl_in} = 2'h0;
    #1;
    chk(aux_write_en_out, 64'h0);
    chk_trap(trap_out, 2'h0);
    @(negedge ref_clk_in);
    req_valid_in = 1'b0;
    $display("test access gate done");
    acc(1'b0, 2'h1, 64'h0);
    chk(rdata_out, 64'h1);
    acc(1'b1, 2'h1, '1);
    acc(1'b0, 2'h1, 64'h0);
    chk(rdata_out, 64'h1);
    $display("test config info done");
    // Field decode for every code, reserved bits set on each write
    for (int k = 0; k < 8; k++)
    begin
      a = k % 4;
      st_hit_unique_in = (k >= 4);
      d = ~MASK | (64'(a) << 38) | (64'(k % 2) << 37) | (64'(a) << 28) | (64'(a) << 26);
      d = d | (64'(a) << 24) | (64'(k % 2) << 22) | (64'(k) << 13) | (64'(k) << 10);
      acc(1'b1, 2'h2, d);
      chk(ectl_out, d & MASK);
      @(negedge ref_clk_in);
      chk(ctrl_out.ld_atomic_near, 64'(a != 2));
      chk(ctrl_out.st_atomic_near, (a == 1) ? 64'h1 : (a == 2) ? 64'h0 : 64'(k >= 4));
      chk(ctrl_out.powerdown_clean_discard, 64'(k % 2));
      chk({ctrl_out.l3_stream_lines, ctrl_out.l3_stream_off}, 64'(l3t[a] * 2 + (a == 3)));
      chk({ctrl_out.l2_stream_lines, ctrl_out.l2_stream_off}, 64'(l2t[a] * 2 + (a == 3)));
      chk({ctrl_out.l1_stream_lines, ctrl_out.l1_stream_off}, 64'(l1t[a] * 2 + (a == 3)));
      chk(ctrl_out.store_buffer_prefetch_train, 64'(k % 2 == 0));
      chk(ctrl_out.l1_prefetch_depth, 64'(k));
      chk({ctrl_out.l3_prefetch_lines, ctrl_out.l3_prefetch_on},
        64'(l3pl[k] * 2 + (l3pl[k] != 0)));
    end
    acc(1'b0, 2'h2, 64'h0);
    chk(rdata_out, d & MASK);
    $display("test extended control done");
    // Reset in mid-run restores the extended control value
    rst_n_in = 1'b0;
    @(negedge ref_clk_in);
    chk(ectl_out, RSTV);
    chk(rdata_out, 64'h0);
    chk(ctrl_out.l1_prefetch_depth, 64'h0);
    rst_n_in = 1'b1;
    @(negedge ref_clk_in);
    chk(ctrl_out.l1_prefetch_depth, 64'h5);
    acc(1'b0, 2'h2, 64'h0);
    chk(rdata_out, RSTV);
    $display("test second reset done");
    wrap_up();
  end
endmodule
